/* logic/file_ram.sv */
`timescale 1ns/100ps
`default_nettype none
// Register file: synchronous write, registered read data.
module file_ram
  import move_exec_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Read port
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [DATA_W-1:0] rdData,
  // Write port
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [DATA_W-1:0] wrData
);

  logic [DATA_W-1:0] mem [FILE_DEPTH];

  // Same-edge read returns the old word; no reset so it maps to block RAM
  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk)
  begin
    rdData <= mem[rdAddr];
  end

endmodule : file_ram
`default_nettype wire

/* logic/logic_move_instr_exec.sv */
`timescale 1ns/100ps
`default_nettype none

module logic_move_instr_exec
  import move_exec_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Instruction issue
  input  wire logic              issueValid,
  input  wire op_t               issueOp,
  input  wire logic [ADDR_W-1:0] fileAddr,
  input  wire logic              destSel,
  input  wire logic [DATA_W-1:0] literal,
  // Results
  output logic      [DATA_W-1:0] acc_ff,
  output logic                   zero_ff,
  output logic                   done_ff,
  output logic                   pcAdvance_ff
);

  // ----------------------------------------------------------------
  // Two-phase sequencer: fetch operand, then execute
  // ----------------------------------------------------------------
  // One instruction cycle = operand read phase + execute phase, since
  // the file read data are registered.
  typedef enum logic {IDLE, EXEC} state_t;

  state_t            state_ff;
  op_t               op_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic              dest_ff;
  logic [DATA_W-1:0] lit_ff;
  logic [DATA_W-1:0] fileData;
  logic [DATA_W-1:0] orResult;
  logic              wrEn;
  logic [DATA_W-1:0] wrData;
  logic              take;
  logic              inExec;
  logic              orToFile;
  logic              storeToFile;

  // ----------------------------------------------------------------
  // Issue acceptance
  // ----------------------------------------------------------------
  // An issue raised during EXEC is dropped with no indication, so the
  // caller must leave one idle clock between two issues.
  // The file still reads the address pins every clock; only a take commits.
  assign take   = issueValid && (state_ff == IDLE);
  assign inExec = (state_ff == EXEC);

  // Two states only: every taken issue spends exactly one clock in EXEC
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff <= IDLE;
    end
    else
    begin
      unique case (state_ff)
        IDLE:
        begin
          if (take)
          begin
            state_ff <= EXEC;
          end
        end
        EXEC:
        begin
          state_ff <= IDLE;
        end
      endcase
    end
  end

  // Operands held through EXEC, so the caller may move its pins after the take
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      op_ff   <= OP_NOP;
      addr_ff <= '0;
      dest_ff <= DEST_ACC;
      lit_ff  <= '0;
    end
    else if (take)
    begin
      op_ff   <= issueOp;
      addr_ff <= fileAddr;
      dest_ff <= destSel;
      lit_ff  <= literal;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Read address comes straight from the pin, not from addr_ff, so the
  // operand is ready in EXEC; reading from the latch would cost a clock.
  // A store lands at the end of EXEC and is readable by the next issue.
  file_ram u_file_ram (
    .clk    (clk),
    .rdAddr (fileAddr),
    .rdData (fileData),
    .wrEn   (wrEn),
    .wrAddr (addr_ff),
    .wrData (wrData)
  );

  // Full 8-bit address reaches the whole 0..FFh file space
  assign orResult = acc_ff | fileData;

  // Write decode: OR with the file as target, and store
  assign orToFile    = inExec && (op_ff == OP_OR_ACC_WITH_FILE) && (dest_ff == DEST_FILE);
  assign storeToFile = inExec && (op_ff == OP_STORE_ACC_TO_FILE);

  // File write only for OR with dest=1 and for store; source kept otherwise
  always_comb
  begin
    wrEn   = 1'b0;
    wrData = acc_ff;
    if (orToFile)
    begin
      wrEn   = 1'b1;
      wrData = orResult;
    end
    else if (storeToFile)
    begin
      wrEn   = 1'b1;
      wrData = acc_ff;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  // Written only at the end of EXEC; an OR with the file as target
  // leaves it alone so the old value is still there for the next issue.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      acc_ff <= ACC_RESET;
    end
    else if (state_ff == EXEC)
    begin
      unique case (op_ff)
        OP_OR_ACC_WITH_FILE:
        begin
          if (dest_ff == DEST_ACC)
          begin
            acc_ff <= orResult;
          end
        end
        OP_COPY_FILE_TO_ACC:  acc_ff <= fileData;
        OP_LOAD_LITERAL_ACC:  acc_ff <= lit_ff;
        OP_STORE_ACC_TO_FILE: acc_ff <= acc_ff;
        OP_NOP:               acc_ff <= acc_ff;
        default:              acc_ff <= acc_ff;   // Unused codes act as no-op
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Zero flag: only the OR instruction touches it
  // ----------------------------------------------------------------
  // Copy, literal load, store and no-op all leave the flag as it was, so
  // only the OR result is ever compared against zero.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      zero_ff <= ZERO_RESET;
    end
    else if (state_ff == EXEC && op_ff == OP_OR_ACC_WITH_FILE)
    begin
      zero_ff <= (orResult == '0);
    end
  end

  // ----------------------------------------------------------------
  // Completion and program counter advance pulses
  // ----------------------------------------------------------------
  // Both pulses stand for one clock, the clock after EXEC; kept as two
  // flops so each output comes straight from its own register.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= inExec;
    end
  end

  // A no-operation still advances the counter; nothing else moves
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pcAdvance_ff <= 1'b0;
    end
    else
    begin
      pcAdvance_ff <= inExec;
    end
  end

endmodule : logic_move_instr_exec
`default_nettype wire

/* logic/move_exec_pkg.sv */
package move_exec_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int FILE_DEPTH = 256;

  // ----------------------------------------------------------------
  // Reset values and destination select
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic       ZERO_RESET = 1'b0;
  localparam logic       DEST_ACC = 1'b0;
  localparam logic       DEST_FILE = 1'b1;

  // ----------------------------------------------------------------
  // Timing: cycles of execution per instruction
  // ----------------------------------------------------------------
  localparam int EXEC_CYCLES = 1;

  // ----------------------------------------------------------------
  // Opcode selector of this datapath
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NOP              = 3'h0,
    OP_OR_ACC_WITH_FILE = 3'h1,
    OP_COPY_FILE_TO_ACC = 3'h2,
    OP_LOAD_LITERAL_ACC = 3'h3,
    OP_STORE_ACC_TO_FILE = 3'h4
  } op_t;

endpackage : move_exec_pkg

/* tb/logic_move_instr_exec_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module logic_move_instr_exec_assertions
  import move_exec_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              resetn,
  // Issue and results
  input wire logic              issueValid,
  input wire op_t               issueOp,
  input wire logic              destSel,
  input wire logic [DATA_W-1:0] literal,
  input wire logic [DATA_W-1:0] acc_ff,
  input wire logic              zero_ff,
  input wire logic              done_ff,
  input wire logic              pcAdvance_ff
);
  logic busy_ff;
  logic taken;
  // Issue in the execute cycle is dropped, so count only real takes
  assign taken = issueValid && !busy_ff;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      busy_ff <= 1'b0;
    else
      busy_ff <= taken;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_pulse;
    !done_ff ##1 (done_ff && pcAdvance_ff) ##1 !done_ff;
  endsequence
  sequence s_kept;
    ##2 (acc_ff == $past(acc_ff, 2)) && (zero_ff == $past(zero_ff, 2));
  endsequence
  property p_pulse; taken |=> s_pulse; endproperty
  property p_load; taken && issueOp == OP_LOAD_LITERAL_ACC |->
    ##2 acc_ff == $past(literal, 2) && zero_ff == $past(zero_ff, 2); endproperty
  property p_store; taken && issueOp == OP_STORE_ACC_TO_FILE |-> s_kept; endproperty
  property p_nop; taken && issueOp == OP_NOP |-> s_kept; endproperty
  property p_orAcc; taken && issueOp == OP_OR_ACC_WITH_FILE && destSel == DEST_ACC |->
    ##2 zero_ff == (acc_ff == 8'h00) && (acc_ff | $past(acc_ff, 2)) == acc_ff; endproperty
  property p_orFile; taken && issueOp == OP_OR_ACC_WITH_FILE && destSel == DEST_FILE |->
    ##2 acc_ff == $past(acc_ff, 2); endproperty
  property p_copy; taken && issueOp == OP_COPY_FILE_TO_ACC |->
    ##2 zero_ff == $past(zero_ff, 2); endproperty
  property p_quiet; $changed(acc_ff) |-> $past(taken, 2); endproperty
  a_pulse: assert property (p_pulse) else $error("done pulse off");
  a_load: assert property (p_load) else $error("literal load wrong");
  a_store: assert property (p_store) else $error("store changed state");
  a_nop: assert property (p_nop) else $error("nop changed state");
  a_orAcc: assert property (p_orAcc) else $error("or to acc wrong");
  a_orFile: assert property (p_orFile) else $error("or to file moved acc");
  a_copy: assert property (p_copy) else $error("copy touched flag");
  a_quiet: assert property (p_quiet) else $error("acc changed idle");
endmodule : logic_move_instr_exec_assertions
bind logic_move_instr_exec logic_move_instr_exec_assertions u_chk (.clk, .resetn,
  .issueValid, .issueOp, .destSel, .literal, .acc_ff, .zero_ff, .done_ff, .pcAdvance_ff);
`default_nettype wire

/* tb/logic_move_instr_exec_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module logic_move_instr_exec_tb;
  import move_exec_pkg::*;
  logic clk = 0, resetn = 0, issueValid = 0, destSel = 0;
  op_t issueOp = OP_NOP;
  logic [7:0] fileAddr = 8'h00, literal = 8'h00, acc_ff;
  logic zero_ff, done_ff, pcAdvance_ff;
  int error_cnt = 0, cmp_count = 0;
  // Row: op, operand (address or literal), dest, expected acc, expected zero
  logic [20:0] rows [16] = '{{3'h3,8'h88,1'b0,8'h88,1'b0}, {3'h4,8'h10,1'b0,8'h88,1'b0},
    {3'h3,8'h23,1'b0,8'h23,1'b0}, {3'h4,8'hff,1'b0,8'h23,1'b0},
    {3'h3,8'h88,1'b0,8'h88,1'b0}, {3'h1,8'hff,1'b1,8'h88,1'b0},
    {3'h2,8'hff,1'b0,8'hab,1'b0}, {3'h3,8'h00,1'b0,8'h00,1'b0},
    {3'h4,8'h30,1'b0,8'h00,1'b0}, {3'h1,8'h30,1'b0,8'h00,1'b1},
    {3'h3,8'h5a,1'b0,8'h5a,1'b1}, {3'h0,8'h00,1'b0,8'h5a,1'b1},
    {3'h7,8'h10,1'b1,8'h5a,1'b1}, {3'h2,8'h10,1'b0,8'h88,1'b1},
    {3'h1,8'h10,1'b0,8'h88,1'b0}, {3'h2,8'h30,1'b0,8'h00,1'b0}};
  always #5 clk = ~clk;
  logic_move_instr_exec u_logic_move_instr_exec (.clk(clk), .resetn(resetn),
    .issueValid(issueValid), .issueOp(issueOp), .fileAddr(fileAddr), .destSel(destSel),
    .literal(literal), .acc_ff(acc_ff), .zero_ff(zero_ff), .done_ff(done_ff),
    .pcAdvance_ff(pcAdvance_ff));
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Issue one instruction, then land just after the result edge
  task automatic exec(logic [20:0] r);
    @(posedge clk);
    issueValid <= 1'b1;
    issueOp <= op_t'(r[20:18]);
    fileAddr <= r[17:10];
    literal <= r[17:10];
    destSel <= r[9];
    @(posedge clk);
    issueValid <= 1'b0;
    @(posedge clk);
    #1;
  endtask : exec
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // Watchdog well past the expected run length
  initial
  begin
    #20000;
    error_cnt++;
    final_report();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    foreach (rows[i])
    begin
      exec(rows[i]);
      chk({6'h00, done_ff, pcAdvance_ff}, 8'h03);
      chk(acc_ff, rows[i][8:1]);
      chk({7'h00, zero_ff}, {7'h00, rows[i][0]});
      $display("row %0d done", i);
    end
    // Second issue in the execute cycle is dropped
    @(posedge clk);
    issueValid <= 1'b1;
    issueOp <= OP_LOAD_LITERAL_ACC;
    literal <= 8'h11;
    @(posedge clk);
    literal <= 8'h22;
    @(posedge clk);
    issueValid <= 1'b0;
    repeat (3) @(posedge clk);
    chk(acc_ff, 8'h11);
    $display("refused issue done");
    // Reset in mid-run, with zero set and a load in flight, clears all
    exec(rows[7]);
    exec(rows[9]);
    @(posedge clk);
    issueValid <= 1'b1;
    issueOp <= OP_LOAD_LITERAL_ACC;
    literal <= 8'h77;
    @(posedge clk);
    issueValid <= 1'b0;
    resetn <= 1'b0;
    @(posedge clk);
    #1;
    chk({5'h00, zero_ff, done_ff, pcAdvance_ff}, 8'h00);
    chk(acc_ff, 8'h00);
    $display("reset done");
    // Release again: the killed load must not surface, then work resumes
    @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({5'h00, zero_ff, done_ff, pcAdvance_ff}, 8'h00);
    chk(acc_ff, 8'h00);
    exec(rows[0]);
    chk({6'h00, done_ff, pcAdvance_ff}, 8'h03);
    chk(acc_ff, rows[0][8:1]);
    $display("restart done");
    final_report();
  end
endmodule : logic_move_instr_exec_tb
`default_nettype wire
